// *** dv/gic_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host model: issues single-byte register writes and reads
module gic_host (
    input  wire logic              sys_clk_i, // System clock
    input  wire logic [7:0]        rdata_i,   // Read data from block
    output gic_pkg::gic_req_t      req_o      // Register request
);
    import gic_pkg::*;
    // Idle bus shows inverted last address and data
    initial req_o = '0;
    // One write, held across one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        req_o = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk_i);
        req_o = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // One read, data taken after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        req_o = '{1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk_i);
        req_o = '{1'b0, 1'b0, ~a, 8'hff};
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the pin configuration block
module testbench;
    import gic_pkg::*;
    typedef struct {logic [7:0] a, r, w, e;} gic_row_t;
    typedef struct {logic [4:0] p; logic [7:0] k; logic e;} gic_stim_t;
    logic       sys_clk_i;   // Clock
    logic       rst_i;       // Reset
    logic       ce_i;        // Clock enable
    logic       irq_clr_i;   // Interrupt clear
    logic [4:0] gp_pin_i;    // Pin levels
    logic [7:0] key_row_i;   // Row levels
    logic [6:0] key_col_i;   // Column levels
    logic [4:0] od_mode_i;   // Open-drain modes
    logic [7:0] rdata_o;     // Read data
    logic [4:0] high_side_o; // Drain side
    logic [4:0] pull_on_o;   // Pull enables
    logic       irq_o;       // Interrupt
    logic [7:0] d;           // Read scratch
    gic_req_t   req;         // Host request
    int         mismatches;  // Failed compares
    int         num_checks;  // All compares
    // Offset, reset value, written value, read-back value
    gic_row_t rows [8] = '{'{8'h36, 8'h1f, 8'hff, 8'h1f},
        '{8'h38, 8'h7f, 8'hff, 8'h7f}, '{8'h39, 8'h00, 8'hff, 8'h1f},
        '{8'h3a, 8'h00, 8'hff, 8'hff}, '{8'h3b, 8'h00, 8'hff, 8'h7f},
        '{8'h3c, 8'h00, 8'hff, 8'h1f}, '{8'h3d, 8'h00, 8'hff, 8'h1f},
        '{8'h40, 8'h00, 8'hff, 8'h00}};
    // Pins, rows, expected interrupt after each step
    gic_stim_t st [11] = '{'{5'h01, 8'h00, 1'b1},
        '{5'h00, 8'h00, 1'b0}, '{5'h02, 8'h00, 1'b0},
        '{5'h00, 8'h00, 1'b0}, '{5'h00, 8'h02, 1'b1},
        '{5'h00, 8'h04, 1'b0}, '{5'h00, 8'h04, 1'b0},
        '{5'h01, 8'h04, 1'b1}, '{5'h00, 8'h04, 1'b1},
        '{5'h00, 8'h02, 1'b1}, '{5'h00, 8'h00, 1'b1}};
    gic_cfg gic_cfg_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .req_i(req), .gp_pin_i(gp_pin_i),
        .key_row_i(key_row_i), .key_col_i(key_col_i),
        .od_mode_i(od_mode_i), .irq_clr_i(irq_clr_i), .rdata_o(rdata_o),
        .high_side_o(high_side_o), .pull_on_o(pull_on_o), .irq_o(irq_o));
    gic_host gic_host_inst (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o),
        .req_o(req));
    // Compare and count
    task automatic chk(input string n, input logic [7:0] s, x);
        num_checks++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Clock
    initial begin
        sys_clk_i = 0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        end_of_test;
    end
    // Main sequence
    initial begin
        {rst_i, ce_i, irq_clr_i, gp_pin_i} = 8'h c0;
        {key_row_i, key_col_i, od_mode_i} = 20'h0000a;
        repeat (5) @(negedge sys_clk_i);
        rst_i = 0;
        foreach (rows[i]) begin
            gic_host_inst.rd(rows[i].a, d);
            chk("reset value", d, rows[i].r);
        end
        $display("register reset test done");
        foreach (rows[i]) begin
            gic_host_inst.wr(rows[i].a, rows[i].w);
            gic_host_inst.rd(rows[i].a, d);
            chk("read back", d, rows[i].e);
        end
        $display("register access test done");
        gic_host_inst.wr(8'h3c, 8'h05);
        gic_host_inst.wr(8'h3d, 8'h1f);
        @(negedge sys_clk_i);
        chk("high side", {3'h0, high_side_o}, 8'h05);
        chk("pull on", {3'h0, pull_on_o}, 8'h0a);
        // New open-drain set and fewer pull bits
        od_mode_i = 5'h15;
        gic_host_inst.wr(8'h3d, 8'h03);
        @(negedge sys_clk_i);
        chk("pull gated", {3'h0, pull_on_o}, 8'h01);
        $display("driver config test done");
        gic_host_inst.wr(8'h36, 8'h1e);
        gic_host_inst.wr(8'h38, 8'h7e);
        gic_host_inst.wr(8'h39, 8'h00);
        gic_host_inst.wr(8'h3b, 8'h80);
        foreach (st[i]) begin
            if (i == 7) gic_host_inst.wr(8'h39, 8'h01);
            if (i == 7) gic_host_inst.wr(8'h3b, 8'h01);
            @(negedge sys_clk_i);
            gp_pin_i = st[i].p;
            key_row_i = st[i].k;
            key_col_i = ~key_col_i;
            repeat (3) @(negedge sys_clk_i);
            chk("irq", {7'h0, irq_o}, {7'h0, st[i].e});
            irq_clr_i = 1;
            @(negedge sys_clk_i);
            irq_clr_i = 0;
        end
        $display("interrupt test done");
        // Clock enable low freezes writes and the interrupt
        ce_i = 0;
        gic_host_inst.wr(8'h3c, 8'h1f);
        gp_pin_i = 5'h01;
        @(negedge sys_clk_i);
        chk("irq frozen", {7'h0, irq_o}, 8'h00);
        ce_i = 1;
        @(negedge sys_clk_i);
        chk("irq after enable", {7'h0, irq_o}, 8'h01);
        gic_host_inst.rd(8'h3c, d);
        chk("frozen write", d, 8'h05);
        // Edge and clear in one cycle: the edge wins
        irq_clr_i = 1;
        gp_pin_i = 5'h00;
        @(negedge sys_clk_i);
        chk("set beats clear", {7'h0, irq_o}, 8'h01);
        @(negedge sys_clk_i);
        chk("irq cleared", {7'h0, irq_o}, 8'h00);
        irq_clr_i = 0;
        gp_pin_i = 5'h01;
        @(negedge sys_clk_i);
        $display("enable and clear test done");
        // Mid-run reset with every output away from zero
        rst_i = 1;
        @(negedge sys_clk_i);
        chk("outs in reset", {2'h0, high_side_o, irq_o}, 8'h00);
        chk("pull in reset", {3'h0, pull_on_o}, 8'h00);
        chk("rdata in reset", rdata_o, 8'h00);
        rst_i = 0;
        gic_host_inst.rd(8'h38, d);
        chk("mask after reset", d, 8'h7f);
        gic_host_inst.rd(8'h3c, d);
        chk("side after reset", d, 8'h00);
        $display("mid-run reset test done");
        end_of_test;
    end
endmodule
`default_nettype wire

// *** hw/gic_cfg.sv ***
`timescale 1ns/100ps
`default_nettype none
module gic_cfg (
    input  wire logic              sys_clk_i,   // System clock
    input  wire logic              rst_i,       // Async reset, high
    input  wire logic              ce_i,        // Clock enable
    input  wire gic_pkg::gic_req_t req_i,       // Register access
    input  wire logic [4:0]        gp_pin_i,    // Pin input levels
    input  wire logic [7:0]        key_row_i,   // Key rows 7..0
    input  wire logic [6:0]        key_col_i,   // Key columns 6..0
    input  wire logic [4:0]        od_mode_i,   // 1 pin is open-drain
    input  wire logic              irq_clr_i,   // Clear interrupt
    output logic      [7:0]        rdata_o,     // Read data
    output logic      [4:0]        high_side_o, // Drain side per pin
    output logic      [4:0]        pull_on_o,   // Pull resistor on
    output logic                   irq_o        // Interrupt out
);
    import gic_pkg::*;

    logic [7:0]  pin_mask_r;   // Pin mask
    logic [7:0]  row_mask_r;   // Upper row mask
    logic [7:0]  pin_edge_r;   // Pin edge mode
    logic [7:0]  low_edge_r;   // Key_line_r_0/column edge mode
    logic [7:0]  row_edge_r;   // Upper row edge mode
    logic [7:0]  drain_r;      // Drain side
    logic [7:0]  pull_r;       // Pull enable
    logic [7:0]  rdata_nxt;    // Read mux
    gic_state_t  state_r;      // Warm-up state
    logic [4:0]  pin_hit;      // Pin edges
    logic [15:0] line_hit;     // Key line edges
    logic [15:0] line_lvl;     // Key line levels
    logic [15:0] line_mask;    // Key line masks
    logic [15:0] line_both;    // Key line modes
    logic        arm;          // History valid
    logic        any_hit;      // Any qualified edge

    // Register writes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_mask_r <= GIC_PIN_MASK_RST;
            row_mask_r <= GIC_ROW_MASK_RST;
            pin_edge_r <= GIC_EDGE_RST;
            low_edge_r <= GIC_EDGE_RST;
            row_edge_r <= GIC_EDGE_RST;
            drain_r    <= GIC_DRAIN_RST;
            pull_r     <= GIC_PULL_RST;
        end else if (ce_i && req_i.wr) begin
            case (req_i.addr)
                GIC_PIN_MASK_OFF: begin
                    pin_mask_r <= req_i.data & GIC_PIN_BITS;
                end
                GIC_ROW_MASK_OFF: begin
                    row_mask_r <= req_i.data & GIC_ROW_BITS;
                end
                GIC_PIN_EDGE_OFF: begin
                    pin_edge_r <= req_i.data & GIC_PIN_BITS;
                end
                GIC_LOW_EDGE_OFF: begin
                    low_edge_r <= req_i.data;
                end
                GIC_ROW_EDGE_OFF: begin
                    row_edge_r <= req_i.data & GIC_ROW_BITS;
                end
                GIC_DRAIN_SIDE_OFF: begin
                    drain_r <= req_i.data & GIC_PIN_BITS;
                end
                GIC_PULL_EN_OFF: begin
                    pull_r <= req_i.data & GIC_PIN_BITS;
                end
                default: begin
                    // Unmapped offsets ignored
                end
            endcase
        end
    end

    // Read mux; unmapped reads zero
    always_comb begin
        case (req_i.addr)
            GIC_PIN_MASK_OFF:   rdata_nxt = pin_mask_r;
            GIC_ROW_MASK_OFF:   rdata_nxt = row_mask_r;
            GIC_PIN_EDGE_OFF:   rdata_nxt = pin_edge_r;
            GIC_LOW_EDGE_OFF:   rdata_nxt = low_edge_r;
            GIC_ROW_EDGE_OFF:   rdata_nxt = row_edge_r;
            GIC_DRAIN_SIDE_OFF: rdata_nxt = drain_r;
            GIC_PULL_EN_OFF:    rdata_nxt = pull_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i && req_i.rd) begin
            rdata_o <= rdata_nxt;
        end
    end

    // Output driver configuration
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_side_o <= 5'h00;
            pull_on_o   <= 5'h00;
        end else if (ce_i) begin
            high_side_o <= drain_r[4:0];
            pull_on_o   <= pull_r[4:0] & od_mode_i;
        end
    end

    // Warm-up: no edge until history captured
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= GIC_IDLE;
        end else if (ce_i) begin
            case (state_r)
                GIC_IDLE: state_r <= GIC_ARM;
                GIC_ARM:  state_r <= GIC_RUN;
                GIC_RUN:  state_r <= GIC_RUN;
                default:  state_r <= GIC_IDLE;
            endcase
        end
    end
    assign arm = (state_r == GIC_RUN);

    // Line bundles: [15:8] rows 7..0, [6:0] columns, [7] spare
    assign line_lvl  = {key_row_i, 1'b0, key_col_i};
    assign line_mask = {row_mask_r[6:0], 1'b1, 1'b1, 7'h7f};
    assign line_both = {row_edge_r[6:0], low_edge_r[7], 1'b0,
                        low_edge_r[6:0]};

    // Pin edges
    gic_edge #(.N(GIC_NPIN)) u_pin (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .arm_i     (arm),
        .lvl_i     (gp_pin_i),
        .mask_i    (pin_mask_r[4:0]),
        .both_i    (pin_edge_r[4:0]),
        .hit_o     (pin_hit)
    );

    // Key line edges (row 0 and columns masked here; their
    // mask lives outside this block)
    gic_edge #(.N(GIC_NLINE)) u_line (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .arm_i     (arm),
        .lvl_i     (line_lvl),
        .mask_i    (line_mask),
        .both_i    (line_both),
        .hit_o     (line_hit)
    );

    assign any_hit = (|pin_hit) | (|line_hit);

    // Sticky interrupt; set wins over clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            if (any_hit) begin
                irq_o <= 1'b1;
            end else if (irq_clr_i) begin
                irq_o <= 1'b0;
            end
        end
    end

    // Register, driver and interrupt checks
    a_mask_reset: assert property (
        @(posedge sys_clk_i) $rose(rst_i) |=> row_mask_r == 8'h7f)
        else $error("Row mask not masked after reset");
    a_row_mask: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && req_i.wr && req_i.addr == GIC_ROW_MASK_OFF
        |=> row_mask_r == ($past(req_i.data) & GIC_ROW_BITS))
        else $error("Row mask write lost");
    a_pin_edge: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && req_i.wr && req_i.addr == GIC_PIN_EDGE_OFF
        |=> pin_edge_r == ($past(req_i.data) & 8'h1f))
        else $error("Pin edge write lost");
    a_low_edge: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && req_i.wr && req_i.addr == GIC_LOW_EDGE_OFF
        |=> low_edge_r == $past(req_i.data))
        else $error("Low edge write lost");
    a_row_top: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        row_edge_r[7] == 1'b0)
        else $error("Row edge top bit set");
    a_drain_side: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i |=> high_side_o == $past(drain_r[4:0]))
        else $error("Drain side output wrong");
    a_pull_gate: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i |=> pull_on_o == ($past(pull_r[4:0]) & $past(od_mode_i)))
        else $error("Pull enable not gated");
    a_pin_mask: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (pin_hit & pin_mask_r[4:0]) == 5'h00)
        else $error("Masked pin produced edge");
    a_irq_set: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && any_hit |=> irq_o)
        else $error("Interrupt not raised");
    a_irq_quiet: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !irq_o && (!ce_i || !any_hit) |=> !irq_o)
        else $error("Spurious interrupt");

    // Scenarios worth seeing

    c_pin_fall: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        |(pin_hit & ~gp_pin_i));
    c_row_hit: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        |line_hit[15:9]);
    c_irq_clear: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_o ##1 !irq_o);
    c_set_clear: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && any_hit && irq_clr_i);
endmodule
`default_nettype wire

// *** hw/gic_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
// Per-line edge detector with mask and edge mode
module gic_edge #(
    parameter int N = 16                 // Line count
) (
    input  wire logic         sys_clk_i, // System clock
    input  wire logic         rst_i,     // Async reset, high
    input  wire logic         ce_i,      // Clock enable
    input  wire logic         arm_i,     // History valid
    input  wire logic [N-1:0] lvl_i,     // Line levels
    input  wire logic [N-1:0] mask_i,    // 1 masks line
    input  wire logic [N-1:0] both_i,    // 1 both edges
    output logic      [N-1:0] hit_o      // Qualified edge
);
    logic [N-1:0] prev_r; // Previous levels

    // Remember last levels
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= '0;
        end else if (ce_i) begin
            prev_r <= lvl_i;
        end
    end

    // Qualify each line
    for (genvar i = 0; i < N; i++) begin : g_line
        logic rise; // Rising edge seen
        logic fall; // Falling edge seen
        assign rise = lvl_i[i] & ~prev_r[i];
        assign fall = ~lvl_i[i] & prev_r[i];
        assign hit_o[i] = arm_i & ~mask_i[i] &
                          (rise | (both_i[i] & fall));
    end
endmodule
`default_nettype wire

// *** shared/gic_pkg.sv ***
`default_nettype none
package gic_pkg;
    // Register offsets (byte-wide register space)
    localparam logic [7:0] GIC_PIN_MASK_OFF    = 8'h36; // Pin interrupt mask
    localparam logic [7:0] GIC_ROW_MASK_OFF    = 8'h38; // Upper row mask
    localparam logic [7:0] GIC_PIN_EDGE_OFF    = 8'h39; // Pin edge select
    localparam logic [7:0] GIC_LOW_EDGE_OFF    = 8'h3a; // Row 0 / column edge
    localparam logic [7:0] GIC_ROW_EDGE_OFF    = 8'h3b; // Upper row edge
    localparam logic [7:0] GIC_DRAIN_SIDE_OFF  = 8'h3c; // Drain side select
    localparam logic [7:0] GIC_PULL_EN_OFF     = 8'h3d; // Pull enable
    // Reset values
    localparam logic [7:0] GIC_PIN_MASK_RST    = 8'h1f; // Pins masked
    localparam logic [7:0] GIC_ROW_MASK_RST    = 8'h7f; // Rows masked
    localparam logic [7:0] GIC_EDGE_RST        = 8'h00; // Rising only
    localparam logic [7:0] GIC_DRAIN_RST       = 8'h00; // Low side
    localparam logic [7:0] GIC_PULL_RST        = 8'h00; // Pulls off
    // Field widths and valid-bit masks
    localparam int         GIC_NPIN            = 5;     // General pins
    localparam int         GIC_NLINE           = 16;    // Key lines
    localparam logic [7:0] GIC_PIN_BITS        = 8'h1f; // Bits 4..0
    localparam logic [7:0] GIC_ROW_BITS        = 8'h7f; // Bits 6..0

    // Register access request
    typedef struct packed {
        logic       wr;   // Write strobe
        logic       rd;   // Read strobe
        logic [7:0] addr; // Register offset
        logic [7:0] data; // Write data
    } gic_req_t;

    // Edge detector states
    typedef enum logic [1:0] {
        GIC_IDLE = 2'b00,
        GIC_ARM  = 2'b01,
        GIC_RUN  = 2'b11
    } gic_state_t;
endpackage
`default_nettype wire
